/* logic/velocity_cmd_pkg.sv */
// constants and carrier types for the analog velocity command block
// assumes 12-bit two's complement converter codes, full scale +/-10 V
package velocity_cmd_pkg;

  localparam int ADC_W = 12;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;

  // register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_VGAIN = 8'h04;
  localparam logic [7:0] OFS_TGAIN = 8'h08;
  localparam logic [7:0] OFS_OFF1 = 8'h0c;
  localparam logic [7:0] OFS_OFF2 = 8'h10;
  localparam logic [7:0] OFS_DB1 = 8'h14;
  localparam logic [7:0] OFS_TYPE = 8'h18;
  localparam logic [7:0] OFS_FUNC2 = 8'h1c;
  localparam logic [7:0] OFS_AUTO = 8'h20;
  localparam logic [7:0] OFS_VCMD = 8'h24;
  localparam logic [7:0] OFS_TLIM = 8'h28;
  localparam logic [7:0] OFS_COND = 8'h2c;

  // reset values, panel units
  localparam logic [4:0] RST_MODE = 5'h07;
  localparam logic signed [15:0] RST_VGAIN = 16'sh12c0;
  localparam logic signed [15:0] RST_TGAIN = 16'sh0064;
  localparam logic signed [15:0] RST_OFF = 16'sh0000;
  localparam logic [7:0] RST_DB = 8'h00;
  localparam logic RST_TYPE = 1'b0;
  localparam logic [1:0] RST_FUNC2 = 2'h3;

  // setting limits, panel units
  localparam logic signed [15:0] OFF_MAX = 16'sh6aa4;
  localparam logic signed [15:0] VGAIN_MAX = 16'sh5dc0;
  localparam logic signed [15:0] TGAIN_MAX = 16'sh07d0;
  localparam logic signed [15:0] FULL_MV = 16'sh2710;

  // scale factors: value * num >>> shift
  localparam logic signed [31:0] MV_PER_CODE = 32'sh0000_0271;
  localparam int MV_PER_CODE_SH = 7;
  localparam logic signed [31:0] MV_PER_OFF = 32'sh0000_5dc5;
  localparam int MV_PER_OFF_SH = 16;
  localparam logic signed [31:0] OFF_PER_MV = 32'sh0000_aeb8;
  localparam int OFF_PER_MV_SH = 14;
  localparam logic signed [63:0] INV_FULL = 64'sh0000_0000_0000_1a37;
  localparam int INV_FULL_SH = 26;

  // mode and function codes
  localparam logic [4:0] MODE_AV_FREE = 5'h0b;
  localparam logic [4:0] MODE_AV_GATED = 5'h0c;
  localparam logic [1:0] FUNC2_TORQUE = 2'h2;
  localparam logic TYPE_DIFF = 1'b1;

  typedef struct packed {
    logic [4:0] main_control_mode;
    logic signed [15:0] velocity_gain;
    logic signed [15:0] torque_gain;
    logic signed [15:0] input_one_offset;
    logic signed [15:0] input_two_offset;
    logic [7:0] input_one_deadband;
    logic analog_input_type;
    logic [1:0] input_two_function;
  } config_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wr_data;
    logic wr_en;
    logic rd_en;
  } bus_req_t;

  typedef struct packed {
    config_t cfg;
    logic signed [15:0] mv1;
    logic signed [15:0] mv2;
    logic signed [15:0] cond1;
    logic signed [15:0] cond2;
    logic signed [15:0] vel_cmd;
    logic motor_run;
    logic signed [15:0] tlim;
    logic tlim_en;
    logic [DATA_W-1:0] rd_data;
  } state_t;

endpackage

/* logic/analog_velocity_command.sv */
// analog velocity command conditioning: offset, deadband, gain, gating
// assumes converter codes and switches synchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - velocity settings and command are held in rps times 240.
// - input one offset register, -10 V to +10 V, resets to zero.
// - input two offset register, -10 V to +10 V, resets to zero.
// - offsets are held in volts times 2730.
// - offset subtracted from sampled voltage; auto offset captures present input.
// - input one deadband register, 0 to 255 mV, resets to zero.
// - run/stop and direction switches used in analog velocity mode.
// - run/stop closed: motor runs at conditioned analog velocity.
// - run/stop open: in mode 12 motor stops regardless of analog input.
// - direction closed reverses command; open has no effect.
// - input type 0 single-ended, 1 differential, reset 0.
// - input two function 2 is torque limit, 3 unused, reset 3.
// - torque limit from input two only in single-ended mode.
// - torque gain gives current at 10 V, resets to 1 A.
// - torque gain held in amperes times 100.
// - velocity gain -100 to +100 rps at 10 V, resets to 20.
// - mode 12 gates with run/stop, mode 11 runs freely.
// - two 12-bit converter inputs.
module analog_velocity_command #(
  parameter int ADC_BITS = velocity_cmd_pkg::ADC_W
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [7:0] addr,
  input wire logic [15:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [15:0] rd_data,
  input wire logic signed [ADC_BITS-1:0] velocity_analog_in,
  input wire logic signed [ADC_BITS-1:0] torque_analog_in,
  input wire logic run_stop_input,
  input wire logic direction_input,
  output logic signed [15:0] velocity_command,
  output logic motor_run,
  output logic signed [15:0] torque_limit,
  output logic torque_limit_en
);

  if (ADC_BITS != 12) begin : g_adc_check
    $error("converter width must be 12 bits");
  end

  velocity_cmd_pkg::state_t st_reg;
  velocity_cmd_pkg::state_t st_next;
  velocity_cmd_pkg::bus_req_t req;

  assign req = '{addr: addr, wr_data: wr_data, wr_en: wr_en, rd_en: rd_en};

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic signed [15:0] sat(input logic signed [31:0] v,
                                             input logic signed [15:0] lim);
    logic signed [31:0] l32;
    l32 = 32'(lim);
    if (v > l32) begin
      sat = lim;
    end else if (v < -l32) begin
      sat = -lim;
    end else begin
      sat = v[15:0];
    end
  endfunction

  function automatic logic [15:0] mag(input logic signed [15:0] v);
    mag = v[15] ? 16'(-v) : 16'(v);
  endfunction

  function automatic logic signed [15:0] scale_full(input logic signed [15:0] a,
                                                    input logic signed [15:0] g);
    logic signed [63:0] p;
    logic neg;
    // scale the magnitude, then restore the sign: truncates toward zero
    p = 64'(a) * 64'(g);
    neg = p < 0;
    if (neg) begin
      p = -p;
    end
    p = (p * velocity_cmd_pkg::INV_FULL) >>> velocity_cmd_pkg::INV_FULL_SH;
    scale_full = neg ? 16'(-p) : 16'(p);
  endfunction

  function automatic logic signed [15:0] mv_of_code(input logic signed [ADC_BITS-1:0] c);
    logic signed [31:0] p;
    p = 32'(c) * velocity_cmd_pkg::MV_PER_CODE;
    mv_of_code = 16'(p >>> velocity_cmd_pkg::MV_PER_CODE_SH);
  endfunction

  function automatic logic signed [15:0] offset_of_mv(input logic signed [15:0] mv);
    logic signed [31:0] p;
    p = 32'(mv) * velocity_cmd_pkg::OFF_PER_MV;
    offset_of_mv = sat(p >>> velocity_cmd_pkg::OFF_PER_MV_SH, velocity_cmd_pkg::OFF_MAX);
  endfunction

  function automatic logic signed [15:0] condition(input logic signed [15:0] mv,
                                                   input logic signed [15:0] off,
                                                   input logic [7:0] db);
    logic signed [31:0] off_mv;
    logic signed [15:0] c;
    off_mv = (32'(off) * velocity_cmd_pkg::MV_PER_OFF) >>> velocity_cmd_pkg::MV_PER_OFF_SH;
    c = sat(32'(mv) - off_mv, velocity_cmd_pkg::FULL_MV);
    condition = (mag(c) <= 16'(db)) ? 16'sh0000 : c;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic signed [15:0] sel1;
    logic signed [15:0] v;
    logic gated;
    logic analog_mode;
    sel1 = 16'sh0000;
    v = 16'sh0000;
    gated = 1'b0;
    analog_mode = 1'b0;
    st_next = st_reg;
    st_next.rd_data = 16'h0000;

    // stage 1: converter codes to millivolts
    st_next.mv1 = mv_of_code(velocity_analog_in);
    st_next.mv2 = mv_of_code(torque_analog_in);

    // stage 2: input select, offset and deadband
    if (st_reg.cfg.analog_input_type == velocity_cmd_pkg::TYPE_DIFF) begin
      sel1 = sat(32'(st_reg.mv1) - 32'(st_reg.mv2), velocity_cmd_pkg::FULL_MV);
    end else begin
      sel1 = st_reg.mv1;
    end
    st_next.cond1 = condition(sel1, st_reg.cfg.input_one_offset,
                              st_reg.cfg.input_one_deadband);
    st_next.cond2 = condition(st_reg.mv2, st_reg.cfg.input_two_offset, 8'h00);

    // stage 3: gain, run/stop, direction, torque limit
    analog_mode = (st_reg.cfg.main_control_mode == velocity_cmd_pkg::MODE_AV_FREE) ||
                  (st_reg.cfg.main_control_mode == velocity_cmd_pkg::MODE_AV_GATED);
    gated = (st_reg.cfg.main_control_mode == velocity_cmd_pkg::MODE_AV_GATED)
            && !run_stop_input;
    v = scale_full(st_reg.cond1, st_reg.cfg.velocity_gain);
    if (direction_input) begin
      v = -v;
    end
    st_next.motor_run = analog_mode && !gated;
    st_next.vel_cmd = (analog_mode && !gated) ? v : 16'sh0000;
    st_next.tlim_en = (st_reg.cfg.analog_input_type != velocity_cmd_pkg::TYPE_DIFF) &&
                      (st_reg.cfg.input_two_function == velocity_cmd_pkg::FUNC2_TORQUE);
    st_next.tlim = st_next.tlim_en ?
                   scale_full(16'(mag(st_reg.cond2)), st_reg.cfg.torque_gain) :
                   16'sh0000;

    // register writes, gains and offsets clamped to the setting ranges
    if (req.wr_en) begin
      unique case (req.addr)
        velocity_cmd_pkg::OFS_MODE:
          st_next.cfg.main_control_mode = req.wr_data[4:0];
        velocity_cmd_pkg::OFS_VGAIN:
          st_next.cfg.velocity_gain = sat(32'(signed'(req.wr_data)),
                                          velocity_cmd_pkg::VGAIN_MAX);
        velocity_cmd_pkg::OFS_TGAIN:
          st_next.cfg.torque_gain = sat(32'(signed'(req.wr_data)),
                                        velocity_cmd_pkg::TGAIN_MAX);
        velocity_cmd_pkg::OFS_OFF1:
          st_next.cfg.input_one_offset = sat(32'(signed'(req.wr_data)),
                                             velocity_cmd_pkg::OFF_MAX);
        velocity_cmd_pkg::OFS_OFF2:
          st_next.cfg.input_two_offset = sat(32'(signed'(req.wr_data)),
                                             velocity_cmd_pkg::OFF_MAX);
        velocity_cmd_pkg::OFS_DB1:
          st_next.cfg.input_one_deadband = req.wr_data[7:0];
        velocity_cmd_pkg::OFS_TYPE:
          st_next.cfg.analog_input_type = req.wr_data[0];
        velocity_cmd_pkg::OFS_FUNC2:
          st_next.cfg.input_two_function = req.wr_data[1:0];
        velocity_cmd_pkg::OFS_AUTO: begin
          if (req.wr_data[0]) begin
            st_next.cfg.input_one_offset = offset_of_mv(st_reg.mv1);
          end
          if (req.wr_data[1]) begin
            st_next.cfg.input_two_offset = offset_of_mv(st_reg.mv2);
          end
        end
        default: ;
      endcase
    end

    // register reads, data in the following cycle only
    if (req.rd_en) begin
      unique case (req.addr)
        velocity_cmd_pkg::OFS_MODE:
          st_next.rd_data = {11'h000, st_reg.cfg.main_control_mode};
        velocity_cmd_pkg::OFS_VGAIN: st_next.rd_data = st_reg.cfg.velocity_gain;
        velocity_cmd_pkg::OFS_TGAIN: st_next.rd_data = st_reg.cfg.torque_gain;
        velocity_cmd_pkg::OFS_OFF1: st_next.rd_data = st_reg.cfg.input_one_offset;
        velocity_cmd_pkg::OFS_OFF2: st_next.rd_data = st_reg.cfg.input_two_offset;
        velocity_cmd_pkg::OFS_DB1: st_next.rd_data = {8'h00, st_reg.cfg.input_one_deadband};
        velocity_cmd_pkg::OFS_TYPE: st_next.rd_data = {15'h0000, st_reg.cfg.analog_input_type};
        velocity_cmd_pkg::OFS_FUNC2: st_next.rd_data = {14'h0000, st_reg.cfg.input_two_function};
        velocity_cmd_pkg::OFS_VCMD: st_next.rd_data = st_reg.vel_cmd;
        velocity_cmd_pkg::OFS_TLIM: st_next.rd_data = st_reg.tlim;
        velocity_cmd_pkg::OFS_COND: st_next.rd_data = st_reg.cond1;
        default: st_next.rd_data = 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      st_reg <= '0;
      st_reg.cfg.main_control_mode <= velocity_cmd_pkg::RST_MODE;
      st_reg.cfg.velocity_gain <= velocity_cmd_pkg::RST_VGAIN;
      st_reg.cfg.torque_gain <= velocity_cmd_pkg::RST_TGAIN;
      st_reg.cfg.input_one_offset <= velocity_cmd_pkg::RST_OFF;
      st_reg.cfg.input_two_offset <= velocity_cmd_pkg::RST_OFF;
      st_reg.cfg.input_one_deadband <= velocity_cmd_pkg::RST_DB;
      st_reg.cfg.analog_input_type <= velocity_cmd_pkg::RST_TYPE;
      st_reg.cfg.input_two_function <= velocity_cmd_pkg::RST_FUNC2;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rd_data = st_reg.rd_data;
  assign velocity_command = st_reg.vel_cmd;
  assign motor_run = st_reg.motor_run;
  assign torque_limit = st_reg.tlim;
  assign torque_limit_en = st_reg.tlim_en;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  sequence gain_read_s;
    rd_en && addr == velocity_cmd_pkg::OFS_VGAIN;
  endsequence

  sequence gated_stop_s;
    st_reg.cfg.main_control_mode == velocity_cmd_pkg::MODE_AV_GATED && !run_stop_input;
  endsequence

  reset_values_a: assert property (disable iff (1'b0)
    $rose(resetn) |-> st_reg.cfg.velocity_gain == 16'sh12c0 &&
      st_reg.cfg.torque_gain == 16'sh0064 && st_reg.cfg.input_two_function == 2'h3)
    else $error("settings not at reset values");

  stop_gate_a: assert property (gated_stop_s |=> velocity_command == 16'sh0000 &&
    !motor_run)
    else $error("motor not stopped with run/stop open");

  free_run_a: assert property (st_reg.cfg.main_control_mode ==
    velocity_cmd_pkg::MODE_AV_FREE |=> motor_run)
    else $error("free analog mode not running");

  run_gain_a: assert property (st_reg.cfg.main_control_mode ==
    velocity_cmd_pkg::MODE_AV_GATED && run_stop_input && !direction_input &&
    st_reg.cond1 == velocity_cmd_pkg::FULL_MV |=>
    velocity_command == $past(st_reg.cfg.velocity_gain))
    else $error("full scale does not give velocity gain");

  reverse_dir_a: assert property (st_reg.cfg.main_control_mode ==
    velocity_cmd_pkg::MODE_AV_FREE && direction_input &&
    st_reg.cond1 == velocity_cmd_pkg::FULL_MV |=>
    velocity_command == -$past(st_reg.cfg.velocity_gain))
    else $error("direction switch does not reverse");

  deadband_zero_a: assert property (st_reg.cond1 == 16'sh0000 ||
    mag(st_reg.cond1) > 16'($past(st_reg.cfg.input_one_deadband)))
    else $error("input inside deadband passed through");

  offset_range_a: assert property (st_reg.cfg.input_one_offset <=
    velocity_cmd_pkg::OFF_MAX && st_reg.cfg.input_one_offset >= -velocity_cmd_pkg::OFF_MAX)
    else $error("input one offset out of range");

  torque_off_a: assert property (st_reg.cfg.analog_input_type ||
    st_reg.cfg.input_two_function != velocity_cmd_pkg::FUNC2_TORQUE |=>
    !torque_limit_en && torque_limit == 16'sh0000)
    else $error("torque limit active when not selected");

  read_gain_a: assert property (gain_read_s |=>
    rd_data == $past(st_reg.cfg.velocity_gain) ##1 (rd_en || rd_data == 16'h0000))
    else $error("gain read data wrong or held");

  sequence run_closed_s;
    st_reg.cfg.main_control_mode == velocity_cmd_pkg::MODE_AV_GATED && run_stop_input;
  endsequence

  sequence other_mode_s;
    st_reg.cfg.main_control_mode != velocity_cmd_pkg::MODE_AV_FREE &&
      st_reg.cfg.main_control_mode != velocity_cmd_pkg::MODE_AV_GATED;
  endsequence

  reset_defaults_a: assert property (disable iff (1'b0)
    $rose(resetn) |-> st_reg.cfg.input_one_offset == velocity_cmd_pkg::RST_OFF &&
      st_reg.cfg.input_two_offset == velocity_cmd_pkg::RST_OFF &&
      st_reg.cfg.input_one_deadband == velocity_cmd_pkg::RST_DB &&
      st_reg.cfg.analog_input_type == velocity_cmd_pkg::RST_TYPE &&
      st_reg.cfg.main_control_mode == velocity_cmd_pkg::RST_MODE)
    else $error("offsets, deadband, type or mode not at reset values");

  run_closed_a: assert property (run_closed_s |=> motor_run)
    else $error("motor not running with run/stop closed");

  other_mode_a: assert property (other_mode_s |=> !motor_run &&
    velocity_command == 16'sh0000)
    else $error("analog command active outside analog velocity mode");

  offset_two_range_a: assert property (st_reg.cfg.input_two_offset <=
    velocity_cmd_pkg::OFF_MAX && st_reg.cfg.input_two_offset >= -velocity_cmd_pkg::OFF_MAX)
    else $error("input two offset out of range");

  gain_range_a: assert property (st_reg.cfg.velocity_gain <=
    velocity_cmd_pkg::VGAIN_MAX && st_reg.cfg.velocity_gain >= -velocity_cmd_pkg::VGAIN_MAX)
    else $error("velocity gain out of range");

  torque_gain_range_a: assert property (st_reg.cfg.torque_gain <=
    velocity_cmd_pkg::TGAIN_MAX && st_reg.cfg.torque_gain >= -velocity_cmd_pkg::TGAIN_MAX)
    else $error("torque gain out of range");

  torque_on_a: assert property (!st_reg.cfg.analog_input_type &&
    st_reg.cfg.input_two_function == velocity_cmd_pkg::FUNC2_TORQUE |=> torque_limit_en)
    else $error("torque limit not enabled when selected");

  read_idle_a: assert property (!rd_en |=> rd_data == 16'h0000)
    else $error("read data present without read strobe");

  deadband_write_a: assert property (wr_en && addr == velocity_cmd_pkg::OFS_DB1 |=>
    st_reg.cfg.input_one_deadband == $past(wr_data[7:0]))
    else $error("deadband write not taken");

  offset_write_a: assert property (wr_en && addr == velocity_cmd_pkg::OFS_OFF1 &&
    signed'(wr_data) <= velocity_cmd_pkg::OFF_MAX &&
    signed'(wr_data) >= -velocity_cmd_pkg::OFF_MAX |=>
    st_reg.cfg.input_one_offset == $past(signed'(wr_data)))
    else $error("offset write not taken");

endmodule // analog_velocity_command

`default_nettype wire

/* testbench/host_model.sv */
// host controller model: drives converter codes and the two switches
// assumes the bench sets targets just after a rising edge of clk_sys
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk_sys,
  input wire logic signed [11:0] code1_set,
  input wire logic signed [11:0] code2_set,
  input wire logic run_set,
  input wire logic dir_set,
  output var logic signed [11:0] velocity_analog_in = 12'h000,
  output var logic signed [11:0] torque_analog_in = 12'h000,
  output var logic run_stop_input = 1'b0,
  output var logic direction_input = 1'b0
);
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    velocity_analog_in <= code1_set;
    torque_analog_in <= code2_set;
    run_stop_input <= run_set;
    direction_input <= dir_set;
  end
endmodule // host_model
`default_nettype wire

/* testbench/tb.sv */
// self-checking bench for the analog velocity command block
// assumes 40 MHz clk_sys, synchronous active low reset
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wr_data = 16'h0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [15:0] rd_data;
  logic signed [11:0] k1 = 12'h000;
  logic signed [11:0] k2 = 12'h000;
  logic run = 1'b0;
  logic dir = 1'b0;
  logic signed [11:0] ain1;
  logic signed [11:0] ain2;
  logic sw_run;
  logic sw_dir;
  logic signed [15:0] vcmd;
  logic signed [15:0] tlim;
  logic mrun;
  logic ten;
  int failures = 0;
  int num_checks = 0;
  int mode = 7, gain = 4800, tg = 100, off1 = 0, off2 = 0, db = 0, typ = 0, f2 = 3;
  int rst_tab[8] = '{7, 4800, 100, 0, 0, 0, 0, 3};
  int modes[3] = '{7, 11, 12};
  always #12.5 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////
  host_model i_host (.clk_sys(clk_sys), .code1_set(k1), .code2_set(k2), .run_set(run),
    .dir_set(dir), .velocity_analog_in(ain1), .torque_analog_in(ain2),
    .run_stop_input(sw_run), .direction_input(sw_dir));
  analog_velocity_command i_dut (.clk_sys(clk_sys), .resetn(resetn), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .velocity_analog_in(ain1), .torque_analog_in(ain2), .run_stop_input(sw_run),
    .direction_input(sw_dir), .velocity_command(vcmd), .motor_run(mrun),
    .torque_limit(tlim), .torque_limit_en(ten));
  ////////////////////////////////////////////////////////////////////////////
  function automatic int mvc(input int c);
    return (c * 625) >>> 7;
  endfunction
  function automatic int cnd(input int mv, input int offp, input int band);
    int c;
    c = mv - ((offp * 24005) >>> 16);
    if (c > 10000) c = 10000;
    if (c < -10000) c = -10000;
    if (c <= band && c >= -band) c = 0;
    return c;
  endfunction
  task chk_v(input logic signed [15:0] got, input int exp, input int tol);
    int d;
    num_checks++;
    d = int'(got) - exp;
    if ((^got === 1'bx) || d > tol || d < -tol) begin
      failures++;
      $display("BAD %0t value %0d expected %0d", $time, got, exp);
    end
  endtask
  task chk_b(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input int exp);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    chk_v(rd_data, exp, 0);
  endtask
  task setr(input logic [7:0] a, input int d);
    wr(a, d[15:0]);
    case (a)
      8'h00: mode = d;
      8'h04: gain = d;
      8'h08: tg = d;
      8'h0c: off1 = d;
      8'h10: off2 = d;
      8'h14: db = d;
      8'h18: typ = d;
      default: f2 = d;
    endcase
  endtask
  task check_out;
    int c1;
    int ev;
    int et;
    logic act;
    repeat (6) @(posedge clk_sys);
    #1;
    c1 = mvc(int'(k1)) - (typ != 0 ? mvc(int'(k2)) : 0);
    if (c1 > 10000) c1 = 10000;
    if (c1 < -10000) c1 = -10000;
    c1 = cnd(c1, off1, db);
    act = (mode == 11) || (mode == 12 && run);
    ev = act ? c1 * gain / 10000 : 0;
    if (dir) ev = -ev;
    et = cnd(mvc(int'(k2)), off2, 0);
    if (et < 0) et = -et;
    et = (typ == 0 && f2 == 2) ? et * tg / 10000 : 0;
    chk_v(vcmd, ev, 2);
    chk_b(mrun, act);
    chk_v(tlim, et, 2);
    chk_b(ten, typ == 0 && f2 == 2);
  endtask
  task apply(input logic signed [11:0] a, input logic signed [11:0] b, input logic r,
    input logic d);
    @(posedge clk_sys);
    k1 <= a;
    k2 <= b;
    run <= r;
    dir <= d;
    check_out;
  endtask
  task finish_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(25 * 40000);
    failures++;
    finish_test;
  end
  initial begin
    void'($urandom(32'h99bc31ef));
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    for (int i = 0; i < 8; i++) rd(8'(i * 4), rst_tab[i]);
    rd(8'h3c, 0);
    wr(8'h24, 16'h1234);
    rd(8'h24, 0);
    wr(8'h0c, 16'h7fff);
    rd(8'h0c, 27300);
    wr(8'h10, 16'h8000);
    rd(8'h10, -27300);
    setr(8'h0c, 0);
    setr(8'h10, 0);
    for (int m = 0; m < 3; m++) begin
      setr(8'h00, modes[m]);
      for (int s = 0; s < 4; s++) apply(12'sd1000, 12'sd0, s[0], s[1]);
    end
    setr(8'h00, 11);
    setr(8'h14, 97);
    apply(12'sd20, 12'sd0, 1'b0, 1'b0);
    setr(8'h14, 96);
    apply(12'sd20, 12'sd0, 1'b0, 1'b0);
    setr(8'h14, 0);
    setr(8'h08, 150);
    for (int t = 0; t < 4; t++) begin
      setr(8'h18, t % 2);
      setr(8'h1c, 2 + t / 2);
      apply(12'sd800, -12'sd300, 1'b1, 1'b0);
    end
    setr(8'h18, 0);
    setr(8'h1c, 2);
    for (int n = 0; n < 20; n++) begin
      setr(8'h00, 11 + $urandom_range(1));
      setr(8'h04, $urandom_range(48000) - 24000);
      setr(8'h0c, $urandom_range(5460) - 2730);
      setr(8'h10, $urandom_range(5460) - 2730);
      setr(8'h14, $urandom_range(255));
      apply(12'($urandom_range(4095)), 12'($urandom_range(4095)), 1'($urandom_range(1)),
        1'($urandom_range(1)));
    end
    setr(8'h00, 11);
    setr(8'h04, 4800);
    setr(8'h0c, 0);
    setr(8'h14, 0);
    apply(12'sd300, 12'sd400, 1'b0, 1'b0);
    wr(8'h20, 16'h0003);
    repeat (6) @(posedge clk_sys);
    #1;
    chk_v(vcmd, 0, 3);
    chk_v(tlim, 0, 1);
    rd(8'h28, 0);
    finish_test;
  end
endmodule // tb
`default_nettype wire
